/* File: hw/seq_pkg.sv */
// Purpose: shared constants for the multi-step speed sequencer
// Assumes: 20 MHz mclk, 32-bit classic Wishbone register bus
// Notes: durations count in tenths of the selected time unit
package seq_pkg;
    // clock and time base
    localparam int CLK_PERIOD_NS = 50;
    localparam longint TENTH_SEC_NS = 100000000;
    localparam int TENTH_CYCLES = int'(TENTH_SEC_NS / CLK_PERIOD_NS);
    localparam int MIN_FACTOR = 60;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DIR = 8'h04;
    localparam logic [7:0] OFS_MAIN = 8'h08;
    localparam logic [7:0] OFS_LIMIT = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_ELAPSED = 8'h14;
    localparam logic [1:0] PAGE_PRESET = 2'h1;
    localparam logic [1:0] PAGE_DUR = 2'h2;

    // control field positions
    localparam int CTRL_CYC_LSB = 0;
    localparam int CTRL_RESTART = 4;
    localparam int CTRL_RETAIN = 5;
    localparam int CTRL_UNIT = 6;

    // status field positions
    localparam int STAT_STAGE_LSB = 0;
    localparam int STAT_RUN = 4;
    localparam int STAT_HOLD = 5;
    localparam int STAT_DIR = 8;
    localparam int STAT_RESUME = 9;

    // reset values, duration ceiling and last stage
    localparam logic [6:0] CTRL_RST = 7'h00;
    localparam logic [15:0] DIR_RST = 16'h0000;
    localparam logic [15:0] MAIN_RST = 16'h01F4;
    localparam logic [15:0] LO_RST = 16'h0000;
    localparam logic [15:0] HI_RST = 16'h01F4;
    localparam logic [15:0] DUR_RST = 16'h0000;
    localparam logic [15:0] DUR_MAX = 16'hFDE8;
    localparam logic [3:0] LAST_STAGE = 4'hF;

    // cycle modes
    localparam logic [1:0] CYC_ONCE = 2'h0;
    localparam logic [1:0] CYC_HOLD = 2'h1;
    localparam logic [1:0] CYC_LOOP = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN = 3'b010,
        ST_HOLD = 3'b100
    } seq_state_t;
endpackage

/* File: hw/seq_time_base.sv */
// Purpose: tick generator, one pulse per tenth of a second or minute
// Assumes: clear restarts the partial interval
// Notes: minute mode divides ticks by sixty
`timescale 1ns/10ps
module seq_time_base
    import seq_pkg::*;
#(
    parameter int TENTH_CYCLES_P = TENTH_CYCLES
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic clear,
    input wire logic minute_sel,
    output logic tick
);
    if (TENTH_CYCLES_P < 1) begin : g_chk
        $error("TENTH_CYCLES_P must be at least one");
    end

    logic [31:0] cyc_reg;
    logic [5:0] sub_reg;
    wire tenth_end = (cyc_reg == 32'(TENTH_CYCLES_P - 1));
    wire sub_end = (sub_reg == 6'(MIN_FACTOR - 1));

    // tick lands on the last tenth of the chain
    assign tick = tenth_end && (!minute_sel || sub_end) && !clear;

    // counters; clear keeps a resumed stage from inheriting a stale fraction
    always_ff @(posedge mclk) begin
        if (srst || clear || tenth_end) begin
            cyc_reg <= 32'h0;
        end else begin
            cyc_reg <= cyc_reg + 32'h1;
        end
        if (srst || clear || !minute_sel || (tenth_end && sub_end)) begin
            sub_reg <= 6'h00;
        end else if (tenth_end) begin
            sub_reg <= sub_reg + 6'h01;
        end
    end
endmodule

/* File: hw/seq_freq_select.sv */
// Purpose: pick the stage frequency and clamp presets to the limits
// Assumes: stage zero follows the main setpoint unclamped
// Notes: output registered, one cycle behind the stage
`timescale 1ns/10ps
module seq_freq_select
    import seq_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic [3:0] stage,
    input wire logic [15:0] main_freq,
    input wire logic [15:0] preset_freq,
    input wire logic [15:0] lo_limit,
    input wire logic [15:0] hi_limit,
    output logic [15:0] freq_out
);
    // clamp presets between lower and upper limit
    wire [15:0] above_lo = (preset_freq < lo_limit) ? lo_limit : preset_freq; // RQ12
    wire [15:0] clamped = (above_lo > hi_limit) ? hi_limit : above_lo; // RQ12
    wire [15:0] pick = (stage == 4'h0) ? main_freq : clamped; // RQ11

    always_ff @(posedge mclk) begin
        if (srst) begin
            freq_out <= 16'h0000;
        end else begin
            freq_out <= pick;
        end
    end
endmodule

/* File: hw/speed_sequencer.sv */
// Purpose: sixteen-stage preset speed sequencer with Wishbone registers
// Assumes: run, stop, fault and power-fail arrive as asynchronous pins
// Notes: retained progress lives outside; restore inputs read once after reset
//
// The implementer's own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps

// Summary of operation
// (RQ1) direction word is sixteen bits, bit n weighted by two to the n
// (RQ2) cycle mode 0: one pass then stop; fresh run needed
// (RQ3) cycle mode 1: after one pass hold last stage frequency and direction
// (RQ4) cycle mode 2: wrap to first stage after each pass until stopped
// (RQ5) restart mode 0: start after stop or fault begins at stage zero
// (RQ6) restart mode 1: record elapsed time, resume that stage for remainder
// (RQ7) retain setting 0 discards progress at power loss, 1 keeps it; boot sees retain at reset value 0, so progress never resumes
// (RQ8) when retaining, save active stage and frequency before power goes
// (RQ9) unit setting 0 counts seconds, 1 counts minutes
// (RQ10) restart mode 0 resumes from stage zero after power returns
// (RQ11) each stage has a duration up to 6500.0; stage zero uses main setpoint
// (RQ12) stages 1 to 15 run clamped presets between lower and upper limit
// (RQ13) advance when elapsed reaches duration, stages in ascending order
// (RQ14) stage direction is direction-word bit at the stage number
module speed_sequencer
    import seq_pkg::*;
#(
    parameter int TENTH_CYCLES_P = TENTH_CYCLES
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic run_cmd,
    input wire logic stop_cmd,
    input wire logic fault_in,
    input wire logic power_fail,
    input wire logic restore_valid,
    input wire logic [3:0] restore_stage,
    input wire logic [15:0] restore_elapsed,
    output logic [15:0] freq_req,
    output logic dir_rev,
    output logic run_active,
    output logic save_strobe,
    output logic save_valid,
    output logic [3:0] save_stage,
    output logic [15:0] save_elapsed,
    output logic [15:0] save_freq
);
    // software settings
    logic [6:0] ctrl_reg;
    logic [15:0] dir_word_reg;
    logic [15:0] main_reg;
    logic [15:0] lo_reg;
    logic [15:0] hi_reg;
    logic [15:0] preset_mem [1:15];
    logic [15:0] dur_mem [0:15];

    // sequencer state
    seq_state_t state_reg;
    seq_state_t state_next;
    logic [3:0] stage_reg;
    logic [3:0] stage_next;
    logic [15:0] elapsed_reg;
    logic [15:0] elapsed_next;
    logic resume_reg;
    logic [3:0] resume_stage_reg;
    logic [15:0] resume_elapsed_reg;
    logic boot_reg;
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic run_prev_reg;
    logic pf_prev_reg;
    logic tick;
    logic [15:0] freq_w;

    wire [1:0] cycle_mode = ctrl_reg[CTRL_CYC_LSB +: 2];
    wire restart_sel = ctrl_reg[CTRL_RESTART];
    wire retain_sel = ctrl_reg[CTRL_RETAIN];
    wire unit_sel = ctrl_reg[CTRL_UNIT];

    // checks below share mclk and sleep through reset
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);

    // pins pass two flops; only the second stage is read
    always_ff @(posedge mclk) begin
        sync1_reg <= {power_fail, fault_in, stop_cmd, run_cmd};
        sync2_reg <= sync1_reg;
    end
    wire run_s = sync2_reg[0];
    wire stop_s = sync2_reg[1];
    wire fault_s = sync2_reg[2];
    wire pf_s = sync2_reg[3];

    // command decode; stop and fault outrank a run edge
    wire halt = stop_s || fault_s;
    wire start = run_s && !run_prev_reg && !halt && (state_reg == ST_IDLE) && !boot_reg;
    wire pf_rise = pf_s && !pf_prev_reg;
    wire resume_ok = restart_sel && resume_reg; // RQ6
    wire stage_done = (elapsed_reg >= dur_mem[stage_reg]); // RQ13
    wire last = (stage_reg == LAST_STAGE);

    seq_time_base #(
        .TENTH_CYCLES_P(TENTH_CYCLES_P)
    ) u_time (
        .mclk(mclk),
        .srst(srst),
        .clear(state_reg != ST_RUN),
        .minute_sel(unit_sel), // RQ9
        .tick(tick)
    );

    seq_freq_select u_freq (
        .mclk(mclk),
        .srst(srst),
        .stage(stage_reg),
        .main_freq(main_reg),
        .preset_freq((stage_reg == 4'h0) ? 16'h0000 : preset_mem[stage_reg]),
        .lo_limit(lo_reg),
        .hi_limit(hi_reg),
        .freq_out(freq_w)
    );

    // sequence state machine
    always_comb begin
        state_next = state_reg;
        stage_next = stage_reg;
        elapsed_next = elapsed_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start && resume_ok) begin
                    state_next = ST_RUN; // RQ6
                    stage_next = resume_stage_reg;
                    elapsed_next = resume_elapsed_reg;
                end else if (start) begin
                    state_next = ST_RUN; // RQ5
                    stage_next = 4'h0;
                    elapsed_next = 16'h0000;
                end
            end
            ST_RUN: begin
                if (halt) begin
                    state_next = ST_IDLE;
                end else if (stage_done && !last) begin
                    stage_next = stage_reg + 4'h1; // RQ13
                    elapsed_next = 16'h0000;
                end else if (stage_done) begin
                    case (cycle_mode)
                        CYC_HOLD: begin
                            state_next = ST_HOLD; // RQ3
                        end
                        CYC_LOOP: begin
                            stage_next = 4'h0; // RQ4
                            elapsed_next = 16'h0000;
                        end
                        default: begin
                            state_next = ST_IDLE; // RQ2
                        end
                    endcase
                end else if (tick) begin
                    elapsed_next = elapsed_reg + 16'h0001; // RQ13
                end
            end
            ST_HOLD: begin
                if (halt) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            state_reg <= ST_IDLE;
            stage_reg <= 4'h0;
            elapsed_reg <= 16'h0000;
            run_prev_reg <= 1'b1;
            pf_prev_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            stage_reg <= stage_next;
            elapsed_reg <= elapsed_next;
            run_prev_reg <= run_s;
            pf_prev_reg <= pf_s;
        end
    end

    // resume point: set on interruption, cleared by a start or by a halt from hold
    always_ff @(posedge mclk) begin
        if (srst) begin
            boot_reg <= 1'b1;
            resume_reg <= 1'b0;
            resume_stage_reg <= 4'h0;
            resume_elapsed_reg <= 16'h0000;
        end else if (boot_reg) begin
            boot_reg <= 1'b0;
            resume_reg <= restore_valid && retain_sel && restart_sel; // RQ7 RQ10
            resume_stage_reg <= restore_stage;
            resume_elapsed_reg <= restore_elapsed;
        end else if (state_reg == ST_RUN && halt) begin
            resume_reg <= 1'b1; // RQ6
            resume_stage_reg <= stage_reg;
            resume_elapsed_reg <= elapsed_reg;
        end else if (start || (state_reg == ST_HOLD && halt)) begin
            resume_reg <= 1'b0;
        end
    end

    // power-fail snapshot for the external store
    always_ff @(posedge mclk) begin
        if (srst) begin
            save_strobe <= 1'b0;
            save_valid <= 1'b0;
            save_stage <= 4'h0;
            save_elapsed <= 16'h0000;
            save_freq <= 16'h0000;
        end else begin
            save_strobe <= pf_rise && retain_sel; // RQ8
            if (pf_rise) begin
                save_valid <= retain_sel && (state_reg == ST_RUN || resume_reg); // RQ7
                save_stage <= (state_reg == ST_RUN) ? stage_reg : resume_stage_reg; // RQ8
                save_elapsed <= (state_reg == ST_RUN) ? elapsed_reg : resume_elapsed_reg;
                save_freq <= freq_w; // RQ8
            end
        end
    end

    // drive outputs; frequency held at zero while idle
    always_ff @(posedge mclk) begin
        if (srst) begin
            dir_rev <= 1'b0;
            run_active <= 1'b0;
        end else begin
            dir_rev <= dir_word_reg[stage_reg]; // RQ14 RQ1
            run_active <= (state_reg != ST_IDLE);
        end
    end
    assign freq_req = run_active ? freq_w : 16'h0000;

    // bus decode
    wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wb_wr = wb_req && wb_we_i;
    wire [3:0] idx = wb_adr_i[5:2];
    wire hit_ctrl = (wb_adr_i == OFS_CTRL);
    wire hit_dir = (wb_adr_i == OFS_DIR);
    wire hit_main = (wb_adr_i == OFS_MAIN);
    wire hit_limit = (wb_adr_i == OFS_LIMIT);
    wire hit_preset = (wb_adr_i[7:6] == PAGE_PRESET) && (idx != 4'h0) && (wb_adr_i[1:0] == 2'h0);
    wire hit_dur = (wb_adr_i[7:6] == PAGE_DUR) && (wb_adr_i[1:0] == 2'h0);
    wire [31:0] bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [31:0] status_w = {22'h0, resume_reg, dir_rev, 2'h0, (state_reg == ST_HOLD),
                            run_active, stage_reg};
    wire [15:0] keep_m = ~bmask[15:0];
    wire [15:0] din_m = wb_dat_i[15:0] & bmask[15:0];
    wire [15:0] dur_wr = (dur_mem[idx] & keep_m) | din_m;
    wire [31:0] rd_w = hit_ctrl ? {25'h0, ctrl_reg} :
                       hit_dir ? {16'h0, dir_word_reg} :
                       hit_main ? {16'h0, main_reg} :
                       hit_limit ? {hi_reg, lo_reg} :
                       (wb_adr_i == OFS_STATUS) ? status_w :
                       (wb_adr_i == OFS_ELAPSED) ? {16'h0, elapsed_reg} :
                       hit_preset ? {16'h0, preset_mem[idx]} :
                       hit_dur ? {16'h0, dur_mem[idx]} : 32'h0000_0000;

    // one-wait-state slave; unmapped reads return zero
    always_ff @(posedge mclk) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? rd_w : 32'h0000_0000;
        end
    end

    // settings writes, byte-lane masked
    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrl_reg <= CTRL_RST;
            dir_word_reg <= DIR_RST;
            main_reg <= MAIN_RST;
            lo_reg <= LO_RST;
            hi_reg <= HI_RST;
        end else if (wb_wr) begin
            if (hit_ctrl && wb_sel_i[0]) begin
                ctrl_reg <= wb_dat_i[6:0];
            end else if (hit_dir) begin
                dir_word_reg <= (dir_word_reg & keep_m) | din_m; // RQ1
            end else if (hit_main) begin
                main_reg <= (main_reg & keep_m) | din_m;
            end else if (hit_limit) begin
                lo_reg <= (lo_reg & keep_m) | din_m;
                hi_reg <= (hi_reg & ~bmask[31:16]) | (wb_dat_i[31:16] & bmask[31:16]);
            end
        end
    end

    // stage tables; durations saturate at the largest setting
    genvar gi;
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_tab
        always_ff @(posedge mclk) begin
            if (srst) begin
                dur_mem[gi] <= DUR_RST;
            end else if (wb_wr && hit_dur && idx == 4'(gi)) begin
                dur_mem[gi] <= (dur_wr > DUR_MAX) ? DUR_MAX : dur_wr; // RQ11
            end
        end
        if (gi > 0) begin : g_pre
            always_ff @(posedge mclk) begin
                if (srst) begin
                    preset_mem[gi] <= 16'(gi * 30);
                end else if (wb_wr && hit_preset && idx == 4'(gi)) begin
                    preset_mem[gi] <= (preset_mem[gi] & keep_m) | din_m; // RQ12
                end
            end
        end
    end

    // checks
    sequence s_pass_end;
        state_reg == ST_RUN && !halt && stage_done && last;
    endsequence

    a_dir_from_word: assert property ( // RQ14
        !$past(srst) |-> dir_rev == $past(dir_word_reg[stage_reg]))
        else $error("bad direction");
    a_once_stops: assert property ( // RQ2
        s_pass_end and cycle_mode == CYC_ONCE |=> state_reg == ST_IDLE ##1 !run_active)
        else $error("no stop");
    a_hold_final: assert property ( // RQ3
        s_pass_end and cycle_mode == CYC_HOLD |=> state_reg == ST_HOLD && stage_reg == LAST_STAGE)
        else $error("no hold");
    a_loop_wrap: assert property ( // RQ4
        s_pass_end and cycle_mode == CYC_LOOP |=> state_reg == ST_RUN && stage_reg == 4'h0)
        else $error("no wrap");
    a_restart_first: assert property ( // RQ5
        start && !restart_sel |=> stage_reg == 4'h0 && elapsed_reg == 16'h0)
        else $error("not stage zero");
    a_resume_stage: assert property ( // RQ6
        start && resume_ok |=> stage_reg == $past(resume_stage_reg) && elapsed_reg == $past(resume_elapsed_reg))
        else $error("no resume");
    a_save_snapshot: assert property ( // RQ8
        pf_rise && retain_sel && state_reg == ST_RUN |=> save_strobe && save_stage == $past(stage_reg))
        else $error("bad snapshot");
    a_stage_advance: assert property ( // RQ13
        state_reg == ST_RUN && !halt && stage_done && !last |=> stage_reg == $past(stage_reg) + 4'h1)
        else $error("no advance");
    a_elapsed_count: assert property ( // RQ9
        state_reg == ST_RUN && !halt && !stage_done && !tick |=> elapsed_reg == $past(elapsed_reg))
        else $error("elapsed drift");
endmodule

/* File: sim/progress_store.sv */
// Purpose: nonvolatile progress store on the far side of the sequencer
// Assumes: a snapshot arrives with a one-cycle save strobe
// Notes: contents outlive the bench reset that stands for power return
`timescale 1ns/10ps
module progress_store (
    input wire logic mclk,
    input wire logic save_strobe,
    input wire logic save_valid,
    input wire logic [3:0] save_stage,
    input wire logic [15:0] save_elapsed,
    output logic restore_valid = 1'b0, // empty store reads invalid
    output logic [3:0] restore_stage = 4'h0,
    output logic [15:0] restore_elapsed = 16'h0
);
    // keep the latest snapshot; no reset, like flash would
    always @(posedge mclk) begin
        if (save_strobe === 1'b1) begin
            restore_valid <= save_valid;
            restore_stage <= save_stage;
            restore_elapsed <= save_elapsed;
        end
    end
endmodule

/* File: sim/test_multi_step_speed_sequencer.sv */
// Purpose: self-checking bench for the speed sequencer
// Assumes: short tick, four cycles per tenth of a second
// Notes: stage order read from distinct frequencies
`timescale 1ns/10ps
module test_multi_step_speed_sequencer
    import seq_pkg::*;
();
    localparam int TC = 4;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_dat = 32'h0;
    logic run_cmd = 1'b0, stop_cmd = 1'b0, fault_in = 1'b0, power_fail = 1'b0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, dir_rev, run_active, save_strobe, save_valid, restore_valid;
    logic [3:0] restore_stage, save_stage;
    logic [15:0] restore_elapsed, save_elapsed, save_freq, freq_req;
    int mismatches = 0;
    int n_compared = 0;
    int cyc = 0, stab = 0;
    logic [16:0] cur = 17'h0;
    logic [16:0] seg_val[$];
    int seg_t[$];
    logic [15:0] pre[16];
    logic [15:0] dur[16];
    logic [15:0] dirw;

    speed_sequencer #(.TENTH_CYCLES_P(TC)) DUT (
        .mclk, .srst, .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o, .wb_ack_o, .run_cmd, .stop_cmd, .fault_in,
        .power_fail, .restore_valid, .restore_stage, .restore_elapsed, .freq_req, .dir_rev,
        .run_active, .save_strobe, .save_valid, .save_stage, .save_elapsed, .save_freq);

    progress_store store (
        .mclk, .save_strobe, .save_valid, .save_stage, .save_elapsed, .restore_valid, .restore_stage,
        .restore_elapsed);

    always #25 mclk = ~mclk;

    // log a command held two cycles
    always @(posedge mclk) begin
        cyc++;
        if ({dir_rev, freq_req} !== cur) begin
            cur = {dir_rev, freq_req};
            stab = 0;
        end else if (stab++ == 0 && run_active === 1'b1 && freq_req != 16'h0000) begin
            seg_val.push_back(cur);
            seg_t.push_back(cyc - 1);
        end
    end

    function automatic logic [16:0] exp_val(input int s);
        logic [15:0] f;
        f = (pre[s] < 16'h0096) ? 16'h0096 : ((pre[s] > 16'h05C8) ? 16'h05C8 : pre[s]);
        return {dirw[s], (s == 0) ? 16'h0014 : f};
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // one classic cycle; entered just after a rising edge
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_dat <= d;
        do begin
            @(posedge mclk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) check("bus ack", 1, wb_ack_o);
        q = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(a, 1'b1, d, q);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string what);
        logic [31:0] q;
        wb(a, 1'b0, 32'h0, q);
        check(what, e, q);
    endtask

    task automatic wait_run(input logic lvl, input int lim);
        int k;
        k = 0;
        while (run_active !== lvl && k < lim) begin
            @(posedge mclk);
            k++;
        end
        check("run_active", lvl, run_active);
    endtask

    task automatic wait_segs(input int n);
        int k;
        k = 0;
        while (seg_val.size() < n && k < 2000) begin
            @(posedge mclk);
            k++;
        end
        check("segment count", 1, seg_val.size() >= n);
    endtask

    task automatic go;
        run_cmd <= 1'b1;
        wait_run(1'b1, 20);
        run_cmd <= 1'b0;
        @(posedge mclk);
    endtask

    // hold stop or fault until idle
    task automatic halt(input int use_fault);
        if (use_fault) fault_in <= 1'b1;
        else stop_cmd <= 1'b1;
        wait_run(1'b0, 20);
        fault_in <= 1'b0;
        stop_cmd <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask

    // check cnt logged stages
    task automatic chk_segs(input int from, input int first, input int cnt);
        int s, len;
        for (int k = 0; k < cnt; k++) begin
            s = (first + k) % 16;
            check("stage value", exp_val(s), seg_val[from + k]);
            if (k < cnt - 1) begin
                len = seg_t[from + k + 1] - seg_t[from + k];
                check("stage length", 1, len >= TC * dur[s] - 3 && len <= TC * dur[s] + 3);
            end
        end
    endtask

    initial begin
        int b, k, len;
        b = $urandom(68173);
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        rd_chk(OFS_CTRL, 32'h0, "control reset");
        rd_chk(OFS_MAIN, 32'h1F4, "main reset");
        rd_chk(OFS_LIMIT, 32'h01F40000, "limit reset");
        for (int i = 0; i < 16; i++) begin
            rd_chk(8'h40 + 8'(4 * i), 32'(30 * i), "preset reset");
            rd_chk(8'h80 + 8'(4 * i), 32'h0, "duration reset");
        end
        wr(8'hFC, $urandom);
        rd_chk(8'hFC, 32'h0, "unmapped read");
        wr(8'h80, 32'h0000FFFF);
        rd_chk(8'h80, 32'h0000FDE8, "duration ceiling");
        for (int i = 0; i < 2; i++) begin
            dirw = i ? 16'($urandom) : 16'h20C2;
            wr(OFS_DIR, {16'($urandom), dirw});
            rd_chk(OFS_DIR, {16'h0, dirw}, "direction word");
        end
        wr(OFS_MAIN, 32'h14);
        wr(OFS_LIMIT, 32'h05C80096);
        for (int i = 0; i < 16; i++) begin
            pre[i] = 16'(100 * i + $urandom_range(50));
            dur[i] = 16'($urandom_range(3, 2));
            if (i > 0) wr(8'h40 + 8'(4 * i), {16'h0, pre[i]});
            wr(8'h80 + 8'(4 * i), {16'h0, dur[i]});
        end
        // one pass, run held high
        b = seg_val.size();
        run_cmd <= 1'b1;
        wait_run(1'b1, 20);
        wait_run(1'b0, 400);
        repeat (30) @(posedge mclk);
        check("idle after pass", 0, run_active);
        chk_segs(b, 0, 16);
        run_cmd <= 1'b0;
        @(posedge mclk);
        wr(OFS_CTRL, 32'h1);
        b = seg_val.size();
        go();
        repeat (300) @(posedge mclk);
        check("hold running", 1, run_active);
        check("hold command", exp_val(15), {dir_rev, freq_req});
        check("hold no advance", b + 16, seg_val.size());
        rd_chk(OFS_STATUS, {23'h0, dirw[15], 8'h3F}, "hold status");
        halt(0);
        // loop mode, ended by stop or fault
        wr(OFS_CTRL, 32'h2);
        for (int f = 0; f < 3; f++) begin
            b = seg_val.size();
            go();
            wait_segs(b + 20);
            chk_segs(b, 0, 20);
            halt(f == 1);
        end
        // resume inside long stage six; start fresh before arming resume
        dur[6] = 16'h000C;
        wr(8'h98, 32'h0000000C);
        b = seg_val.size();
        go();
        wr(OFS_CTRL, 32'h12);
        wait_segs(b + 7);
        repeat (20) @(posedge mclk);
        halt(0);
        b = seg_val.size();
        go();
        wait_segs(b + 2);
        check("resumed stage", exp_val(6), seg_val[b]);
        len = seg_t[b + 1] - seg_t[b];
        check("remaining time", 1, len >= 12 && len <= 36);
        check("after resume", exp_val(7), seg_val[b + 1]);
        halt(0);
        // minute unit
        dur[0] = 16'h0001;
        wr(8'h80, 32'h1);
        wr(OFS_CTRL, 32'h42);
        b = seg_val.size();
        go();
        wait_segs(b + 2);
        check("first after switch", exp_val(0), seg_val[b]);
        len = seg_t[b + 1] - seg_t[b];
        check("minute stage", 1, len >= TC * 60 - 4 && len <= TC * 60 + 4);
        halt(0);
        // snapshot only while retaining
        wr(OFS_CTRL, 32'h22);
        b = seg_val.size();
        go();
        wait_segs(b + 3);
        for (int r = 1; r >= 0; r--) begin
            wr(OFS_CTRL, r ? 32'h22 : 32'h02);
            wait_segs(seg_val.size() + 1);
            power_fail <= 1'b1;
            k = 0;
            do begin
                @(posedge mclk);
                k++;
            end while (save_strobe !== 1'b1 && k < 8);
            check("save strobe", r, save_strobe);
            if (r == 1) begin
                check("save valid", 1, save_valid);
                check("save stage", (seg_val.size() - 1 - b) % 16, save_stage);
                check("save freq", exp_val((seg_val.size() - 1 - b) % 16) & 17'hFFFF, save_freq);
                check("save elapsed", 1, save_elapsed <= dur[save_stage]);
            end
            power_fail <= 1'b0;
            repeat (4) @(posedge mclk);
        end
        // power return restarts at stage zero
        srst <= 1'b1;
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        wr(8'h80, 32'h5);
        b = seg_val.size();
        go();
        wait_segs(b + 1);
        check("after power return", 17'h001F4, seg_val[b]);
        halt(0);
        print_verdict();
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        $display("unexpected watchdog expected done seen timeout");
        print_verdict();
    end
endmodule
